// ---- logic/tacq_pkg.sv ----
// Constants, register map and carrier types for trigger/acquisition control.
// Assumes one 250 MHz clock and samples arriving with a valid strobe.
// Functional notes
// - Auto mode: timeout max(pretrig,100ms)+10ms forces update
// - Normal mode: update only on trigger
// - Exactly one selected trigger source
// - Coupling choice only for channel/external sources
// - Direct coupling uses signal as delivered
// - Low-frequency suppress removes content up to 50kHz
// - Rising slope: below level to above
// - Falling slope: above level to below
// - Separate trigger level per channel
// - External level within four volts, 0.1V steps
// - Circular overwrite until trigger, then retain
// - Position 0 div centres trigger point
// - Zero delay puts trigger at position
// - Digitizer pretrigger count 0 to record length
// - Scope delay 1ns to 300s after trigger
// - Digitizer delay samples up to 200,000,000
// - Bus line triggers on false-to-true
// - Drive bus true from trigger until done; code does not drive when the trigger source is a bus line
package tacq_pkg;
  localparam int CLK_KHZ = 250000;
  localparam int CLK_NS = 4;
  localparam int AUTO_MIN_PRE_MS = 100;
  localparam int AUTO_PAD_MS = 10;
  localparam int AUTO_MIN_PRE_CYC = AUTO_MIN_PRE_MS * CLK_KHZ;
  localparam int AUTO_PAD_CYC = AUTO_PAD_MS * CLK_KHZ;
  localparam int LF_CUT_KHZ = 50;
  localparam int LF_SHIFT = $clog2(CLK_KHZ / (6 * LF_CUT_KHZ));
  localparam logic [39:0] DLY_DIG_MAX = 40'h000BEBC200;
  localparam logic [39:0] DLY_NS_MIN = 40'h0000000001;
  localparam logic [39:0] DLY_NS_MAX = 40'h45D964B800;
  localparam int NCH = 4;
  localparam int SW = 8;
  localparam int AW = 10;
  localparam logic [10:0] DEPTH = 11'h400;
  localparam logic signed [7:0] EXT_LVL_MAX = 8'sh28;
  localparam logic signed [3:0] POS_MAX = 4'sh5;
  localparam logic [3:0] DIVS = 4'hA;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CHLVL = 8'h08;
  localparam logic [7:0] OFF_EXTLVL = 8'h0C;
  localparam logic [7:0] OFF_RECLEN = 8'h10;
  localparam logic [7:0] OFF_PRETRIG = 8'h14;
  localparam logic [7:0] OFF_POS = 8'h18;
  localparam logic [7:0] OFF_DLYLO = 8'h1C;
  localparam logic [7:0] OFF_DLYHI = 8'h20;
  localparam logic [7:0] OFF_RDADDR = 8'h24;
  localparam logic [7:0] OFF_RDDATA = 8'h28;
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_AUTO = 2;
  localparam int CTRL_DIGI = 3;
  localparam int CTRL_FALL = 4;
  localparam int CTRL_LFREJ = 5;
  localparam int CTRL_BUSOUT = 6;
  localparam int CTRL_OUTLINE = 7;
  localparam int CTRL_SRC = 8;
  localparam logic [10:0] CTRL_RST = 11'h004;
  localparam logic [10:0] RECLEN_RST = 11'h400;
  localparam logic [2:0] SRC_BUS1 = 3'h0;
  localparam logic [2:0] SRC_BUS2 = 3'h1;
  localparam logic [2:0] SRC_EXT_HI = 3'h2;
  localparam logic [2:0] SRC_EXT_LO = 3'h3;
  typedef struct packed {
    logic valid;
    logic [SW-1:0] ext;
    logic [NCH-1:0][SW-1:0] ch;
  } tacq_smp_s;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FILL = 6'h02,
    ST_WAIT = 6'h04,
    ST_DELAY = 6'h08,
    ST_POST = 6'h10,
    ST_DONE = 6'h20
  } tacq_state_e;
endpackage

// ---- logic/tacq_top.sv ----
// Trigger source select, slope detect and circular acquisition store.
// Assumes an AHB-Lite master, one sample per valid strobe, signed codes.
`timescale 1ns/100ps
module tacq_top #(
  parameter int MIN_PRE_CYC = tacq_pkg::AUTO_MIN_PRE_CYC,
  parameter int PAD_CYC = tacq_pkg::AUTO_PAD_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tacq_pkg::tacq_smp_s smpIn,
  input wire logic [1:0] busTrigIn,
  output logic [1:0] busTrigOut,
  output logic [1:0] busTrigOe,
  output logic extLowImp,
  output logic displayUpdate,
  output logic acqBusy
);
  import tacq_pkg::*;

  localparam int LPW = SW + 2 + LF_SHIFT;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic [10:0] clampLen(input logic [31:0] v, input logic [10:0] mx);
    logic [10:0] r;
    r = (v > 32'(mx)) ? mx : v[10:0];
    return r;
  endfunction

  function automatic logic [39:0] clampDly(input logic [39:0] v, input logic [39:0] lo,
                                            input logic [39:0] hi);
    logic [39:0] r;
    r = (v < lo) ? lo : ((v > hi) ? hi : v);
    return r;
  endfunction

  // AHB-Lite slave
  logic wrPend_reg, rdPend_reg, hready_reg;
  logic [7:0] aOff_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rdMux;
  wire addrOk = hsel && htrans[1] && hready;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      aOff_reg <= 8'h00;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
    end else begin
      wrPend_reg <= addrOk && hwrite;
      rdPend_reg <= addrOk && !hwrite;
      if (addrOk) begin
        aOff_reg <= haddr[7:0];
      end
      // Reads take one wait state so read data leaves a flop
      hready_reg <= !(addrOk && !hwrite);
      if (rdPend_reg) begin
        hrdata_reg <= rdMux;
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;

  // Register file
  logic [10:0] ctrl_reg, recLen_reg, preCnt_reg;
  logic [NCH-1:0][SW-1:0] chLvl_reg;
  logic signed [7:0] extLvl_reg;
  logic signed [3:0] pos_reg;
  logic [31:0] dlyLo_reg;
  logic [7:0] dlyHi_reg;
  logic [AW-1:0] rdAddr_reg;
  logic [31:0] rdData_reg;

  wire wCtrl = wrPend_reg && hit(aOff_reg, OFF_CTRL);
  wire startReq = wCtrl && hwdata[CTRL_START];
  wire abortReq = wCtrl && hwdata[CTRL_ABORT];
  wire signed [7:0] wExt = hwdata[7:0];
  wire signed [3:0] wPos = hwdata[3:0];
  wire [31:0] wRec = (hwdata == 32'h0) ? 32'h1 : hwdata;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RST;
      recLen_reg <= RECLEN_RST;
      preCnt_reg <= 11'h000;
      chLvl_reg <= '0;
      extLvl_reg <= 8'sh00;
      pos_reg <= 4'sh0;
      dlyLo_reg <= 32'h00000000;
      dlyHi_reg <= 8'h00;
      rdAddr_reg <= '0;
    end else begin
      if (wCtrl) begin
        ctrl_reg <= {hwdata[10:2], 2'b00};
      end
      if (wrPend_reg && hit(aOff_reg, OFF_RECLEN)) begin
        recLen_reg <= clampLen(wRec, DEPTH);
      end
      if (wrPend_reg && hit(aOff_reg, OFF_PRETRIG)) begin
        preCnt_reg <= clampLen(hwdata, DEPTH);
      end
      if (wrPend_reg && hit(aOff_reg, OFF_CHLVL)) begin
        chLvl_reg <= hwdata;
      end
      if (wrPend_reg && hit(aOff_reg, OFF_EXTLVL)) begin
        extLvl_reg <= (wExt > EXT_LVL_MAX) ? EXT_LVL_MAX :
                      ((wExt < -EXT_LVL_MAX) ? -EXT_LVL_MAX : wExt);
      end
      if (wrPend_reg && hit(aOff_reg, OFF_POS)) begin
        pos_reg <= (wPos > POS_MAX) ? POS_MAX : ((wPos < -POS_MAX) ? -POS_MAX : wPos);
      end
      if (wrPend_reg && hit(aOff_reg, OFF_DLYLO)) begin
        dlyLo_reg <= hwdata;
      end
      if (wrPend_reg && hit(aOff_reg, OFF_DLYHI)) begin
        dlyHi_reg <= hwdata[7:0];
      end
      if (wrPend_reg && hit(aOff_reg, OFF_RDADDR)) begin
        rdAddr_reg <= hwdata[AW-1:0];
      end
    end
  end

  wire autoMode = ctrl_reg[CTRL_AUTO];
  wire digiMode = ctrl_reg[CTRL_DIGI];
  wire [2:0] src = ctrl_reg[CTRL_SRC +: 3];

  // Window geometry
  wire [10:0] preDigi = (preCnt_reg > recLen_reg) ? recLen_reg : preCnt_reg;
  wire [3:0] posSteps = 4'(POS_MAX - pos_reg);
  wire [14:0] preProd = 15'(recLen_reg) * 15'(posSteps);
  // Position 0 div gives half record
  wire [10:0] preScope = 11'(preProd / 15'(DIVS));
  wire [10:0] preLen = digiMode ? preDigi : preScope;
  wire [10:0] postLen = recLen_reg - preLen;
  wire [39:0] dlyRaw = {dlyHi_reg, dlyLo_reg};
  wire [39:0] dlyDigi = (dlyRaw > DLY_DIG_MAX) ? DLY_DIG_MAX : dlyRaw;
  wire [39:0] dlyNs = clampDly(dlyRaw, DLY_NS_MIN, DLY_NS_MAX);
  wire [39:0] dlyScope = (dlyNs + 40'(CLK_NS - 1)) / 40'(CLK_NS);
  wire [39:0] dlyCyc = digiMode ? dlyDigi : dlyScope;
  wire [31:0] preCyc = (32'(preLen) > 32'(MIN_PRE_CYC)) ? 32'(preLen) : 32'(MIN_PRE_CYC);
  wire [31:0] tmoLimit = preCyc + 32'(PAD_CYC);

  // Source select
  // One source feeds detection
  wire srcIsBus = (src == SRC_BUS1) || (src == SRC_BUS2);
  wire [SW-1:0] rawCode = src[2] ? smpIn.ch[src[1:0]] : smpIn.ext;
  wire signed [SW+1:0] rawSel = 10'($signed(rawCode));
  wire signed [SW+1:0] lvlSel = src[2] ? 10'($signed(chLvl_reg[src[1:0]])) :
                                         10'(extLvl_reg);

  // Single-pole high-pass; coarse corner, trades accuracy for no multipliers
  logic signed [LPW-1:0] lpAcc_reg;
  wire signed [SW+1:0] lpVal = 10'(lpAcc_reg >>> LF_SHIFT);
  wire signed [SW+1:0] hpVal = rawSel - lpVal;
  // Coupling applies to analog sources only
  wire useLf = ctrl_reg[CTRL_LFREJ] && !srcIsBus;
  // Direct path is the raw sample
  wire signed [SW+1:0] trigVal = useLf ? hpVal : rawSel;
  wire above = trigVal >= lvlSel;

  logic prevAbove_reg, prevBus_reg, prevValid_reg;
  wire busNow = busTrigIn[src[0]];
  wire busEdge = !prevBus_reg && busNow;
  wire riseEdge = !prevAbove_reg && above;
  wire fallEdge = prevAbove_reg && !above;
  wire slopeHit = ctrl_reg[CTRL_FALL] ? fallEdge : riseEdge;
  wire trigHit = smpIn.valid && prevValid_reg && (srcIsBus ? busEdge : slopeHit);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lpAcc_reg <= '0;
      prevAbove_reg <= 1'b0;
      prevBus_reg <= 1'b0;
      prevValid_reg <= 1'b0;
    end else if (smpIn.valid) begin
      lpAcc_reg <= lpAcc_reg + LPW'(hpVal);
      prevAbove_reg <= above;
      prevBus_reg <= busNow;
      prevValid_reg <= 1'b1;
    end
  end

  // Acquisition sequencer
  tacq_state_e state_reg, state_next;
  logic [39:0] cnt_reg, cnt_next;
  logic [31:0] tmo_reg;
  logic [AW-1:0] wrPtr_reg, trigAddr_reg;
  logic triggered_reg, forced_reg, update_reg, busy_reg, extLo_reg;
  // Nonzero line vector means driving
  logic [1:0] outLine_reg;

  wire running = (state_reg == ST_FILL) || (state_reg == ST_WAIT) ||
                 (state_reg == ST_DELAY) || (state_reg == ST_POST);
  wire storeSmp = running && smpIn.valid;
  // Only auto mode may time out
  wire timedOut = autoMode && (tmo_reg >= tmoLimit);
  wire [AW-1:0] lastPtr = AW'(recLen_reg - 11'h001);
  wire [AW-1:0] wrPtrInc = (wrPtr_reg == lastPtr) ? '0 : wrPtr_reg + 1'b1;
  wire [39:0] cntInc = smpIn.valid ? cnt_reg + 40'h1 : cnt_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (startReq) begin
          state_next = ST_FILL;
          cnt_next = '0;
        end
      end
      ST_FILL: begin
        if (cnt_reg >= 40'(preLen)) begin
          state_next = ST_WAIT;
        end else begin
          cnt_next = cntInc;
        end
        if (timedOut) begin
          state_next = ST_DONE;
        end
      end
      ST_WAIT: begin
        // Trigger beats a coincident timeout
        if (trigHit) begin
          // Zero delay goes straight to post
          state_next = (dlyCyc == 40'h0) ? ST_POST : ST_DELAY;
          cnt_next = 40'h1;
        end else if (timedOut) begin
          state_next = ST_DONE;
        end
      end
      ST_DELAY: begin
        if (cnt_reg >= dlyCyc) begin
          state_next = ST_POST;
          cnt_next = '0;
        end else begin
          cnt_next = cntInc;
        end
      end
      ST_POST: begin
        if (cnt_reg >= 40'(postLen)) begin
          state_next = ST_DONE;
        end else begin
          cnt_next = cntInc;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next = '0;
      end
    endcase
    if (abortReq) begin
      state_next = ST_IDLE;
    end
  end

  wire enterDone = (state_next == ST_DONE) && (state_reg != ST_DONE);
  wire armHit = (state_reg == ST_WAIT) && trigHit && !abortReq;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      tmo_reg <= 32'h00000000;
      wrPtr_reg <= '0;
      trigAddr_reg <= '0;
      triggered_reg <= 1'b0;
      forced_reg <= 1'b0;
      outLine_reg <= 2'b00;
      update_reg <= 1'b0;
      busy_reg <= 1'b0;
      extLo_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      tmo_reg <= (state_reg == ST_IDLE || state_reg == ST_DONE) ? 32'h0 : tmo_reg + 32'h1;
      if (startReq && !running) begin
        wrPtr_reg <= '0;
      end else if (storeSmp) begin
        wrPtr_reg <= wrPtrInc;
      end
      if (startReq && !running) begin
        triggered_reg <= 1'b0;
        forced_reg <= 1'b0;
      end
      if (armHit) begin
        trigAddr_reg <= wrPtr_reg;
        triggered_reg <= 1'b1;
      end
      if (enterDone && !triggered_reg && !armHit) begin
        forced_reg <= 1'b1;
      end
      if (armHit && ctrl_reg[CTRL_BUSOUT] && !srcIsBus) begin
        outLine_reg <= ctrl_reg[CTRL_OUTLINE] ? 2'b10 : 2'b01;
      end else if (state_next == ST_DONE || state_next == ST_IDLE) begin
        outLine_reg <= 2'b00;
      end
      update_reg <= enterDone;
      busy_reg <= (state_next != ST_IDLE) && (state_next != ST_DONE);
      extLo_reg <= (src == SRC_EXT_LO);
    end
  end

  // Sample store
  logic [31:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (storeSmp) begin
      mem[wrPtr_reg] <= smpIn.ch;
    end
    rdData_reg <= mem[rdAddr_reg];
  end

  wire [31:0] status = {4'h0, trigAddr_reg, wrPtr_reg, forced_reg, triggered_reg, state_reg};

  assign rdMux = hit(aOff_reg, OFF_CTRL) ? {21'h0, ctrl_reg} :
                 hit(aOff_reg, OFF_STATUS) ? status :
                 hit(aOff_reg, OFF_CHLVL) ? chLvl_reg :
                 hit(aOff_reg, OFF_EXTLVL) ? 32'(extLvl_reg) :
                 hit(aOff_reg, OFF_RECLEN) ? {21'h0, recLen_reg} :
                 hit(aOff_reg, OFF_PRETRIG) ? {21'h0, preCnt_reg} :
                 hit(aOff_reg, OFF_POS) ? 32'(pos_reg) :
                 hit(aOff_reg, OFF_DLYLO) ? dlyLo_reg :
                 hit(aOff_reg, OFF_DLYHI) ? {24'h0, dlyHi_reg} :
                 hit(aOff_reg, OFF_RDADDR) ? {22'h0, rdAddr_reg} :
                 hit(aOff_reg, OFF_RDDATA) ? rdData_reg : 32'h00000000;

  // Bus line is true-driven only while enabled
  // One flop per line, so pins carry no gate glitches
  assign busTrigOut = outLine_reg;
  assign busTrigOe = outLine_reg;
  assign extLowImp = extLo_reg;
  assign displayUpdate = update_reg;
  assign acqBusy = busy_reg;
endmodule

// ---- tb/tacq_front_model.sv ----
// Behavioural front end and station bus lines for the trigger block.
// Assumes the bench steers level, sample pace and bus requests.
`timescale 1ns/100ps
module tacq_front_model
  import tacq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic lvlHigh,
  input wire logic slow,
  input wire logic [1:0] busReq,
  output tacq_pkg::tacq_smp_s smp,
  output logic [1:0] busLine
);
  logic pace;
  logic take;
  logic [SW-1:0] code;
  assign code = lvlHigh ? 8'h10 : 8'hF0;
  assign take = ~slow | pace;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pace <= 1'b0;
      smp <= '0;
      busLine <= 2'h0;
    end else begin
      pace <= ~pace;
      // station line steps false to true
      busLine <= busReq;
      smp.valid <= take;
      // Between samples data is inverted so stale codes never pass
      // external input fed like channel one
      smp.ext <= take ? code : ~code;
      for (int i = 0; i < NCH; i++) begin
        smp.ch[i] <= take ? code : ~code;
      end
    end
  end
endmodule

// ---- tb/tacq_monitor.sv ----
// Port checker for the trigger and acquisition block.
// Assumes a bind onto tacq_top; one clock, synchronous reset.
`timescale 1ns/100ps
module tacq_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hreadyout,
  input wire logic [1:0] busTrigOut,
  input wire logic [1:0] busTrigOe,
  input wire logic displayUpdate,
  input wire logic acqBusy
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_drive_eq;
    busTrigOut == busTrigOe;
  endproperty
  a_drive_eq: assert property (p_drive_eq) else $error("bus drive and enable differ");
  property p_one_line;
    $onehot0(busTrigOe);
  endproperty
  a_one_line: assert property (p_one_line) else $error("two bus lines driven");
  property p_drive_hold;
    (|busTrigOut && acqBusy) |=> (busTrigOut == $past(busTrigOut)) || !acqBusy;
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("bus drive dropped early");
  property p_drive_end;
    $fell(acqBusy) |-> ##[0:1] busTrigOut == 2'h0;
  endproperty
  a_drive_end: assert property (p_drive_end) else $error("bus drive outlives capture");
  property p_upd_pulse;
    displayUpdate |=> !displayUpdate;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update longer than one cycle");
  property p_upd_after;
    displayUpdate |-> $past(acqBusy) || $past(acqBusy, 2);
  endproperty
  a_upd_after: assert property (p_upd_after) else $error("update without acquisition");
  property p_upd_idle;
    displayUpdate |-> !acqBusy;
  endproperty
  a_upd_idle: assert property (p_upd_idle) else $error("update while still capturing");
  property p_trig_in_acq;
    $rose(|busTrigOut) |-> $past(acqBusy);
  endproperty
  a_trig_in_acq: assert property (p_trig_in_acq) else $error("trigger outside capture");
  c_update: cover property (displayUpdate);
  c_drive: cover property ($rose(|busTrigOut));
  c_wait: cover property (!hreadyout);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the trigger and acquisition block.
// Assumes short timeout parameters: 200 plus 20 cycles.
`timescale 1ns/100ps
module testbench;
  import tacq_pkg::*;
  localparam int TMO = 220;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  tacq_smp_s smpIn;
  logic [1:0] busReq = 2'h0;
  logic [1:0] busLine;
  logic [1:0] busWire;
  logic [1:0] busTrigOut;
  logic [1:0] busTrigOe;
  logic extLowImp;
  logic displayUpdate;
  logic acqBusy;
  logic lvlHigh = 1'b0;
  logic slow = 1'b0;
  int error_cnt = 0;
  int checked = 0;
  // Station lines are wired: any driver pulls true
  assign busWire = busLine | (busTrigOut & busTrigOe);
  always #2 sys_clk = ~sys_clk;
  tacq_top #(.MIN_PRE_CYC(200), .PAD_CYC(20)) tacq_top_inst (
    .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .smpIn(smpIn), .busTrigIn(busWire),
    .busTrigOut(busTrigOut), .busTrigOe(busTrigOe), .extLowImp(extLowImp),
    .displayUpdate(displayUpdate), .acqBusy(acqBusy));
  tacq_front_model tacq_front_model_inst (
    .sys_clk(sys_clk), .srst(srst), .lvlHigh(lvlHigh), .slow(slow), .busReq(busReq),
    .smp(smpIn), .busLine(busLine));
  task summarize;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0, v);
  endtask
  task waitUpd(input int maxc, output int n, output logic [1:0] drv);
    n = 0;
    drv = 2'h0;
    while (displayUpdate !== 1'b1 && n < maxc) begin
      @(posedge sys_clk);
      drv = drv | busTrigOut;
      n++;
    end
    if (displayUpdate !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask
  task regReset;
    logic [31:0] v;
    rd(OFF_CTRL, v);
    chk(v, 32'h00000004);
    chk({31'h0, hresp}, 32'h0);
    rd(OFF_RECLEN, v);
    chk(v, 32'h00000400);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    rd(OFF_STATUS, v);
    chk(v & 32'hFF, 32'h01);
    rd(8'h3C, v);
    chk(v, 32'h0);
    wr(OFF_RECLEN, 32'h8);
    wr(OFF_PRETRIG, 32'h2);
    wr(OFF_CHLVL, 32'h0);
    wr(OFF_EXTLVL, 32'h0);
  endtask
  // Trigger on a level step; checks drive, timing and retained sample
  task trigEdge(input logic [31:0] ctrl, input logic from, input logic pace, input logic [1:0] e);
    logic [31:0] v;
    logic [1:0] d;
    int n;
    lvlHigh <= from;
    slow <= pace;
    wr(OFF_CTRL, ctrl);
    wr(OFF_CTRL, ctrl | 32'h1);
    chk(extLowImp, ctrl[10:8] == SRC_EXT_LO);
    repeat (12) @(posedge sys_clk);
    rd(OFF_STATUS, v);
    chk(v & 32'h3F, 32'h04);
    chk(busTrigOut, 2'h0);
    lvlHigh <= ~from;
    waitUpd(60, n, d);
    chk(d, e);
    chk(n <= 24, 1'b1);
    rd(OFF_STATUS, v);
    chk(v & 32'hFF, 32'h60);
    wr(OFF_RDADDR, {22'h0, v[27:18]});
    rd(OFF_RDDATA, v);
    chk(v[7:0], from ? 8'hF0 : 8'h10);
  endtask
  task noTrig(input logic [31:0] ctrl);
    logic [31:0] v;
    logic [1:0] d;
    int n;
    lvlHigh <= 1'b0;
    wr(OFF_CTRL, ctrl);
    wr(OFF_CTRL, ctrl | 32'h1);
    if (ctrl[CTRL_AUTO]) begin
      waitUpd(400, n, d);
      chk(n >= TMO - 2 && n <= TMO + 6, 1'b1);
      rd(OFF_STATUS, v);
      chk(v[7:6], 2'h2);
    end else begin
      n = 0;
      repeat (300) begin
        @(posedge sys_clk);
        n += int'(displayUpdate === 1'b1);
      end
      chk(n, 0);
      wr(OFF_CTRL, ctrl | 32'h2);
      rd(OFF_STATUS, v);
      chk(v & 32'h3F, 32'h01);
    end
  endtask
  task busTrig(input logic [31:0] ctrl, input logic [1:0] line);
    logic [1:0] d;
    int n;
    slow <= 1'b0;
    busReq <= 2'h0;
    wr(OFF_DLYLO, 32'd30);
    wr(OFF_CTRL, ctrl);
    wr(OFF_CTRL, ctrl | 32'h1);
    repeat (12) @(posedge sys_clk);
    busReq <= line;
    waitUpd(200, n, d);
    chk(d, 2'h0);
    chk(n >= 30 && n <= 50, 1'b1);
    busReq <= 2'h0;
    wr(OFF_DLYLO, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    regReset();
    for (int c = 4; c < 8; c++) begin
      trigEdge((c << 8) | 32'h48, 1'b0, 1'b0, 2'h1);
    end
    trigEdge(32'h3D8, 1'b1, 1'b1, 2'h2);
    trigEdge(32'h2D8, 1'b1, 1'b1, 2'h2);
    trigEdge(32'h740, 1'b0, 1'b0, 2'h1);
    noTrig(32'h408);
    noTrig(32'h40C);
    busTrig(32'h008, 2'h1);
    busTrig(32'h108, 2'h2);
    summarize();
  end
endmodule
bind tacq_top tacq_monitor tacq_monitor_inst (
  .sys_clk(sys_clk), .srst(srst), .hreadyout(hreadyout), .busTrigOut(busTrigOut),
  .busTrigOe(busTrigOe), .displayUpdate(displayUpdate), .acqBusy(acqBusy));
